// file: design/psram_init_controller.sv
// Controller end: drives select and restore pins, gates requests.
// Assumes supply_ok from a board sensor and synchronous inputs.
module psram_init_controller
  import pwr_seq_pkg::*;
#(
  parameter int INIT_CYCLES = POWER_UP_INIT_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  pwr_seq_if.controller pins,
  input wire logic supply_ok,
  input wire logic supply_dip,
  input wire logic restore_req,
  input wire logic xfer_req,
  output logic ready,
  output logic xfer_grant,
  output logic data_lost
);
  typedef enum logic [2:0] {
    C_POWER = 3'b000,
    C_INIT = 3'b001,
    C_PULSE = 3'b010,
    C_GAP = 3'b011,
    C_READY = 3'b100
  } ctl_state_t;

  ctl_state_t state, next_state;
  logic [CNT_BITS-1:0] count, next_count;
  logic [CNT_BITS-1:0] fall_count, next_fall_count;
  logic next_select_n, next_restore_low, next_ready;
  logic next_grant, next_lost;
  logic select_n_q, restore_low_q;
  logic restore_start;

  // Saturating step; a long stay in one state must never wrap a count
  function automatic logic [CNT_BITS-1:0] step(
    input logic [CNT_BITS-1:0] value);
    step = (value == '1) ? value : value + 1'b1;
  endfunction

  // Greater of both constraints on the release gap
  function automatic logic gap_done(input logic [CNT_BITS-1:0] gap,
                                    input logic [CNT_BITS-1:0] fall);
    gap_done = (gap >= CNT_BITS'(RESTORE_RELEASE_CYCLES))
      && (fall >= CNT_BITS'(RESTORE_FALL_CYCLES));
  endfunction

  // Restore trigger: a dip in any powered state, a request only when ready
  always_comb
  begin
    restore_start = 1'b0;
    if (supply_ok && state != C_POWER)
      restore_start = supply_dip
        || (restore_req && state == C_READY);
  end

  // Sequencing; a dip forces a fresh restore pulse
  always_comb
  begin
    next_state = state;
    next_count = step(count);
    next_fall_count = step(fall_count);
    if (!supply_ok)
    begin
      next_state = C_POWER;
      next_count = '0;
    end
    else if (restore_start)
    begin
      // Retrigger restarts both gap counts, so a held dip stays safe
      next_state = C_PULSE;
      next_count = '0;
      next_fall_count = '0;
    end
    else
    begin
      unique case (state)
        C_POWER:
        begin
          next_state = C_INIT;
          next_count = '0;
        end
        C_INIT:
          if (count >= CNT_BITS'(INIT_CYCLES - 1))
            next_state = C_READY;
        C_PULSE:
          if (count >= CNT_BITS'(RESTORE_PULSE_CYCLES - 1))
          begin
            next_state = C_GAP;
            next_count = '0;
          end
        C_GAP:
          if (gap_done(step(count), step(fall_count)))
            next_state = C_READY;
        C_READY:
          next_state = C_READY;
      endcase
    end
  end

  // Restore pin and ready follow next_state, select follows next_grant, so each leaves a flop
  always_comb
  begin
    next_lost = data_lost;
    next_grant = 1'b0;
    if (supply_ok && state == C_READY && !restore_start)
    begin
      next_grant = xfer_req;
      if (xfer_req)
        next_lost = 1'b0;
    end
    // A restore in the same cycle as a transfer wins
    if (restore_start)
      next_lost = 1'b1;
    next_restore_low = (next_state != C_PULSE);
    // Select idles high; pulsed low one cycle per granted transfer
    next_select_n = !next_grant;
    next_ready = (next_state == C_READY);
  end

  // Sequencing registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= C_POWER;
      count <= '0;
      fall_count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      fall_count <= next_fall_count;
    end
  end

  // Pin and status registers; pins come straight from flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      select_n_q <= 1'b1;
      restore_low_q <= 1'b1;
      ready <= 1'b0;
      xfer_grant <= 1'b0;
      data_lost <= 1'b1;
    end
    else
    begin
      select_n_q <= next_select_n;
      restore_low_q <= next_restore_low;
      ready <= next_ready;
      xfer_grant <= next_grant;
      data_lost <= next_lost;
    end
  end

  assign pins.select_n_pin = select_n_q;
  assign pins.hard_restore_low = restore_low_q;
endmodule

// file: design/pwr_seq_pkg.sv
// Shared constants for the power-up and hardware-restore sequencing pair.
// Assumes both ends run on one 10 MHz clock.
package pwr_seq_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Times in their printed units
  localparam int POWER_UP_INIT_TIME_US = 150;
  localparam int RESTORE_PULSE_WIDTH_NS = 200;
  localparam int RESTORE_RELEASE_TO_SELECT_NS = 200;
  localparam int RESTORE_FALL_TO_SELECT_NS = 400;
  localparam int BROWNOUT_LOW_DURATION_1V8_US = 30;
  localparam int BROWNOUT_LOW_DURATION_3V0_US = 50;
  // Cycle counts, least times rounded up
  localparam int POWER_UP_INIT_CYCLES =
    (POWER_UP_INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_PULSE_CYCLES =
    (RESTORE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_RELEASE_CYCLES =
    (RESTORE_RELEASE_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_FALL_CYCLES =
    (RESTORE_FALL_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device configuration default and refresh row counter reset value
  localparam logic [15:0] CONFIG_DEFAULT = 16'h8f1f;
  localparam logic [12:0] ROW_COUNT_RESET = 13'h0000;
  localparam int ROW_BITS = 13;
  localparam int CNT_BITS = 16;
endpackage

// file: design/pwr_seq_if.sv
// Pins between the memory controller and the memory device.
// Assumes one shared clock; both pins are driven by the controller only.
interface pwr_seq_if;
  logic select_n_pin;
  logic hard_restore_low;
  modport controller (output select_n_pin, output hard_restore_low);
  modport memory (input select_n_pin, input hard_restore_low);
endinterface

// file: design/psram_init_device.sv
// Device end: self-initialization, restore handling and refresh walk.
// Assumes the controller keeps its timing; supply_ok comes from a sensor.
module psram_init_device
  import pwr_seq_pkg::*;
#(
  parameter int INIT_CYCLES = POWER_UP_INIT_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  pwr_seq_if.memory pins,
  input wire logic supply_ok,
  output logic device_ready,
  output logic refresh_active,
  output logic [ROW_BITS-1:0] refresh_row,
  output logic [15:0] config_reg,
  output logic access_seen
);
  typedef enum logic [1:0] {
    D_OFF = 2'b00,
    D_INIT = 2'b01,
    D_READY = 2'b10
  } dev_state_t;

  dev_state_t state, next_state;
  logic [CNT_BITS-1:0] count, next_count;
  logic [ROW_BITS-1:0] next_refresh_row;
  logic next_device_ready, next_refresh_active, next_access_seen;
  logic [15:0] next_config_reg;

  // Next-state logic; a low restore pin overrides everything except a lost supply
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_refresh_row = refresh_row;
    next_config_reg = config_reg;
    next_access_seen = 1'b0;
    if (!supply_ok)
    begin
      next_state = D_OFF;
      next_count = '0;
      next_refresh_row = ROW_COUNT_RESET;
      next_config_reg = CONFIG_DEFAULT;
    end
    else if (!pins.hard_restore_low)
    begin
      next_state = (state == D_OFF) ? D_OFF : D_READY;
      next_config_reg = CONFIG_DEFAULT;
      next_refresh_row = ROW_COUNT_RESET;
      next_count = '0;
    end
    else
    begin
      // Refresh runs whenever the pin is high: resumes unasked
      next_refresh_row = refresh_row + 1'b1;
      unique case (state)
        D_OFF:
        begin
          next_state = D_INIT;
          next_count = '0;
        end
        D_INIT:
        begin
          if (count >= CNT_BITS'(INIT_CYCLES - 1))
            next_state = D_READY;
          else
            next_count = count + 1'b1;
        end
        D_READY:
          next_access_seen = !pins.select_n_pin;
      endcase
    end
    next_device_ready = (next_state == D_READY);
    next_refresh_active = supply_ok && pins.hard_restore_low
      && (state != D_OFF);
  end

  // Registers only; power-on reset mimics a dead supply
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= D_OFF;
      count <= '0;
      refresh_row <= ROW_COUNT_RESET;
      config_reg <= CONFIG_DEFAULT;
      device_ready <= 1'b0;
      refresh_active <= 1'b0;
      access_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      refresh_row <= next_refresh_row;
      config_reg <= next_config_reg;
      device_ready <= next_device_ready;
      refresh_active <= next_refresh_active;
      access_seen <= next_access_seen;
    end
  end
endmodule

// file: verif/pwr_seq_checker.sv
// Concurrent checks on the select and restore pins.
// Assumes one clock and a synchronous active-high reset.
module pwr_seq_checker
  import pwr_seq_pkg::*;
#(
  parameter int INIT_CYCLES = POWER_UP_INIT_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic select_n_pin,
  input wire logic hard_restore_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] since;
  logic [15:0] next_since;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Cycles since reset; saturates so a long run never wraps
  always_comb
  begin
    next_since = (since == 16'hffff) ? since : since + 16'h0001;
    if (reset)
      next_since = 16'h0000;
  end
  always_ff @(posedge clk)
  begin
    since <= next_since;
  end
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> select_n_pin && hard_restore_low)
    else $error("pins not idle after reset");
  init_hold_a: assert property (
    since < INIT_CYCLES |-> select_n_pin)
    else $error("select during init");
  pulse_low_a: assert property ($fell(hard_restore_low) |->
    !hard_restore_low [*2])
    else $error("restore pulse too short");
  pulse_end_a: assert property (!hard_restore_low |->
    ##[1:8] hard_restore_low)
    else $error("restore pulse never ends");
  release_gap_a: assert property ($rose(hard_restore_low) |->
    select_n_pin [*2])
    else $error("select too soon after release");
  fall_select_a: assert property ($fell(hard_restore_low) |->
    select_n_pin [*4])
    else $error("select too soon after restore fall");
  hold_off_a: assert property (
    !hard_restore_low |-> select_n_pin)
    else $error("select while restore low");
  gap_past_a: assert property ($fell(select_n_pin) |->
    hard_restore_low && $past(hard_restore_low, 2))
    else $error("select without release gap");
  // Main scenarios reached
  cover property ($fell(hard_restore_low));
  cover property ($rose(hard_restore_low));
  cover property ($fell(select_n_pin));
endmodule

// file: verif/psram_power_up_and_reset_sequencing_bench.sv
// Bench joining controller and device through the pin interface.
// Assumes a short init count so the run stays brief.
module psram_power_up_and_reset_sequencing_bench
  import pwr_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT = 20;
  logic clk, reset, supply_ok, supply_dip, restore_req, xfer_req;
  logic ready, xfer_grant, data_lost, device_ready, refresh_active;
  logic access_seen;
  logic [ROW_BITS-1:0] refresh_row;
  logic [15:0] config_reg;
  int mismatches, check_count, cycles, k;
  pwr_seq_if link();
  psram_init_controller #(.INIT_CYCLES(INIT)) psram_init_controller_inst (
    .clk(clk), .reset(reset), .pins(link), .supply_ok(supply_ok),
    .supply_dip(supply_dip), .restore_req(restore_req),
    .xfer_req(xfer_req), .ready(ready), .xfer_grant(xfer_grant),
    .data_lost(data_lost));
  psram_init_device #(.INIT_CYCLES(INIT)) psram_init_device_inst (
    .clk(clk), .reset(reset), .pins(link), .supply_ok(supply_ok),
    .device_ready(device_ready), .refresh_active(refresh_active),
    .refresh_row(refresh_row), .config_reg(config_reg),
    .access_seen(access_seen));
  pwr_seq_checker #(.INIT_CYCLES(INIT)) pwr_seq_checker_inst (
    .clk(clk), .reset(reset), .select_n_pin(link.select_n_pin),
    .hard_restore_low(link.hard_restore_low));
  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task check_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait; the count lets callers judge timing
  task automatic wait_on(ref logic s, input logic v);
    k = 0;
    while (s !== v && k < 40)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // Hang guard, well above the fewer than a hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      mismatches++;
      close_out;
    end
  end
  initial
  begin
    {reset, supply_ok, supply_dip, restore_req, xfer_req} = 5'h10;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    supply_ok = 1'b1;
    // Early requests must be ignored until every wait is met
    {restore_req, xfer_req} = 2'h3;
    repeat (INIT / 2) @(negedge clk);
    check_bit(refresh_active, 1'b1);
    check_bit(refresh_row != ROW_COUNT_RESET, 1'b1);
    check_bit(ready, 1'b0);
    check_bit(xfer_grant, 1'b0);
    check_bit(link.select_n_pin, 1'b1);
    check_bit(link.hard_restore_low, 1'b1);
    check_bit(device_ready, 1'b0);
    {restore_req, xfer_req} = 2'h0;
    wait_on(ready, 1'b1);
    check_bit(ready, 1'b1);
    check_bit(k >= INIT / 2, 1'b1);
    wait_on(device_ready, 1'b1);
    check_bit(device_ready, 1'b1);
    $display("test power_up done");
    xfer_req = 1'b1;
    @(negedge clk);
    xfer_req = 1'b0;
    check_bit(xfer_grant, 1'b1);
    check_bit(link.select_n_pin, 1'b0);
    @(negedge clk);
    check_bit(access_seen, 1'b1);
    check_bit(data_lost, 1'b0);
    $display("test transfer done");
    {restore_req, xfer_req} = 2'h3;
    @(negedge clk);
    restore_req = 1'b0;
    wait_on(link.hard_restore_low, 1'b0);
    @(negedge clk);
    check_bit(ready, 1'b0);
    check_bit(data_lost, 1'b1);
    check_word(config_reg, CONFIG_DEFAULT);
    check_bit(refresh_active, 1'b0);
    check_word({3'h0, refresh_row}, {3'h0, ROW_COUNT_RESET});
    check_bit(device_ready, 1'b1);
    check_bit(xfer_grant, 1'b0);
    wait_on(link.hard_restore_low, 1'b1);
    @(negedge clk);
    check_bit(refresh_active, 1'b1);
    check_bit(refresh_row != ROW_COUNT_RESET, 1'b1);
    wait_on(ready, 1'b1);
    check_bit(k <= 4, 1'b1);
    @(negedge clk);
    check_bit(xfer_grant, 1'b1);
    xfer_req = 1'b0;
    $display("test restore done");
    supply_dip = 1'b1;
    @(negedge clk);
    supply_dip = 1'b0;
    wait_on(link.hard_restore_low, 1'b0);
    check_bit(k <= 2, 1'b1);
    check_bit(data_lost, 1'b1);
    check_bit(ready, 1'b0);
    wait_on(ready, 1'b1);
    check_bit(ready, 1'b1);
    $display("test supply_dip done");
    close_out;
  end
endmodule
